//--- regfile_host_pkg.sv
// Constants for the controller of a 16x4 asynchronous register file.
// Assumes a 40 MHz system clock and a single external memory device.
package regfile_host_pkg;
    localparam int WORD_COUNT  = 16;
    localparam int WORD_WIDTH  = 4;
    localparam int INDEX_WIDTH = 4;
    localparam int CLOCK_PERIOD_NS = 25;
    // Least write strobe width and least select pulse width, in ns
    localparam int WRITE_PULSE_NS  = 8;
    localparam int SELECT_PULSE_NS = 18;
    // Longest address access time, in ns
    localparam int ACCESS_NS       = 15;
    localparam int WRITE_PULSE_CYCLES  = (WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SELECT_PULSE_CYCLES = (SELECT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int ACCESS_CYCLES       = (ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [3:0] COUNT_ZERO  = 4'h0;
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [3:0] DATA_RESET  = 4'h0;
    typedef enum logic [2:0] {
        IDLE, SETUP, STROBE, HOLD, READ_WAIT, READ_CAPTURE
    } host_state_t;
endpackage

//--- regfile_host.sv
// Controller that writes and reads a 16x4 asynchronous register file through its pins.
// Assumes the device's outputs are open-emitter and may be wire-ORed with other devices.
//
// Overview of operation
// - Drive all four index lines every access
// - Only one select asserted when wire-ORed
// - Normal write: set index, data, select before strobe
// - Strobe-by-select write holds index, data
`timescale 1ns/100ps
module regfile_host
    import regfile_host_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   reqValid,
    input  wire logic                   reqWrite,
    input  wire logic                   strobeBySelect,
    input  wire logic [INDEX_WIDTH-1:0] reqIndex,
    input  wire logic [WORD_WIDTH-1:0]  reqData,
    output logic                        reqReady,
    output logic                        rspValid,
    output logic [WORD_WIDTH-1:0]       rspData,
    output logic [INDEX_WIDTH-1:0]      word_index,
    output logic [WORD_WIDTH-1:0]       write_data_in,
    output logic                        selectN,
    output logic                        writeStrobeN,
    input  wire logic [WORD_WIDTH-1:0]  read_data_out
);
    host_state_t            state_q, state_d;
    logic [3:0]             count_q, count_d;
    logic                   modeSel_q, modeSel_d;
    logic [INDEX_WIDTH-1:0] index_q, index_d;
    logic [WORD_WIDTH-1:0]  data_q, data_d;
    logic                   sel_q, sel_d, we_q, we_d;
    logic                   ready_q, ready_d, rspValid_q, rspValid_d;
    logic [WORD_WIDTH-1:0]  rsp_q, rsp_d;
    logic [WORD_WIDTH-1:0]  readSync1_q, readSync2_q;

    // Pin input synchroniser
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readSync1_q <= DATA_RESET;
            readSync2_q <= DATA_RESET;
        end else begin
            readSync1_q <= read_data_out;
            readSync2_q <= readSync1_q;
        end
    end

    always_comb begin
        state_d    = state_q;
        count_d    = count_q;
        modeSel_d  = modeSel_q;
        index_d    = index_q;
        data_d     = data_q;
        sel_d      = sel_q;
        we_d       = we_q;
        ready_d    = ready_q;
        rspValid_d = 1'b0;
        rsp_d      = rsp_q;
        unique case (state_q)
            IDLE: begin
                ready_d = 1'b1;
                sel_d   = 1'b1;
                we_d    = 1'b1;
                if (reqValid && ready_q) begin
                    ready_d   = 1'b0;
                    index_d   = reqIndex;
                    data_d    = reqData;
                    modeSel_d = strobeBySelect;
                    count_d   = COUNT_ZERO;
                    if (reqWrite) begin
                        state_d = SETUP;
                        // Strobe-by-select: strobe low first, select stays high
                        sel_d = strobeBySelect;
                        we_d  = !strobeBySelect;
                    end else begin
                        state_d = READ_WAIT;
                        sel_d   = 1'b0;
                        we_d    = 1'b1;
                    end
                end
            end
            SETUP: begin
                state_d = STROBE;
                if (modeSel_q) begin
                    sel_d = 1'b0;
                end else begin
                    we_d = 1'b0;
                end
            end
            STROBE: begin
                if (count_q == 4'(WRITE_PULSE_CYCLES + SELECT_PULSE_CYCLES - 1)
                    || (!modeSel_q && count_q == 4'(WRITE_PULSE_CYCLES - 1))) begin
                    state_d = HOLD;
                    count_d = COUNT_ZERO;
                    if (modeSel_q) begin
                        sel_d = 1'b1;
                    end else begin
                        we_d = 1'b1;
                    end
                end else begin
                    count_d = count_q + 4'h1;
                end
            end
            HOLD: begin
                // Index and data kept one cycle past the rising edge
                state_d = IDLE;
                sel_d   = 1'b1;
                we_d    = 1'b1;
                ready_d = 1'b1;
            end
            READ_WAIT: begin
                // Access time plus two synchroniser stages
                if (count_q == 4'(ACCESS_CYCLES + 1)) begin
                    state_d = READ_CAPTURE;
                end else begin
                    count_d = count_q + 4'h1;
                end
            end
            READ_CAPTURE: begin
                rsp_d      = readSync2_q;
                rspValid_d = 1'b1;
                sel_d      = 1'b1;
                state_d    = IDLE;
                ready_d    = 1'b1;
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q    <= IDLE;
            count_q    <= COUNT_ZERO;
            modeSel_q  <= 1'b0;
            index_q    <= INDEX_RESET;
            data_q     <= DATA_RESET;
            sel_q      <= 1'b1;
            we_q       <= 1'b1;
            ready_q    <= 1'b0;
            rspValid_q <= 1'b0;
            rsp_q      <= DATA_RESET;
        end else begin
            state_q    <= state_d;
            count_q    <= count_d;
            modeSel_q  <= modeSel_d;
            index_q    <= index_d;
            data_q     <= data_d;
            sel_q      <= sel_d;
            we_q       <= we_d;
            ready_q    <= ready_d;
            rspValid_q <= rspValid_d;
            rsp_q      <= rsp_d;
        end
    end

    assign reqReady      = ready_q;
    assign rspValid      = rspValid_q;
    assign rspData       = rsp_q;
    assign word_index    = index_q;
    assign write_data_in = data_q;
    assign selectN       = sel_q;
    assign writeStrobeN  = we_q;

    // Assertions
    a_index_stable_write: assert property (@(posedge clock) disable iff (!resetn)
        (!selectN && !writeStrobeN) |=> $stable(word_index) && $stable(write_data_in))
        else $error("Index or data changed during write");
    a_strobe_after_select: assert property (@(posedge clock) disable iff (!resetn)
        $fell(writeStrobeN) && !modeSel_q |-> !selectN && $stable(word_index))
        else $error("Strobe fell without select set up");
    a_select_strobe_mode: assert property (@(posedge clock) disable iff (!resetn)
        $fell(selectN) && modeSel_q && state_q == STROBE |-> !writeStrobeN && !$past(writeStrobeN))
        else $error("Select strobe without prior write strobe");
    a_hold_after_rise: assert property (@(posedge clock) disable iff (!resetn)
        $rose(selectN) && state_q == HOLD |=> $past(word_index, 2) == $past(word_index))
        else $error("Index not held after select rise");
    a_read_strobe_high: assert property (@(posedge clock) disable iff (!resetn)
        state_q == READ_WAIT |-> writeStrobeN && !selectN)
        else $error("Read without strobe high and select low");
    a_read_latency: assert property (@(posedge clock) disable iff (!resetn)
        state_q == IDLE && reqValid && reqReady && !reqWrite |-> ##[4:5] rspValid)
        else $error("Read response out of bounds");
    a_write_pulse_width: assert property (@(posedge clock) disable iff (!resetn)
        $fell(writeStrobeN) && !modeSel_q |-> !writeStrobeN [*1] ##1 writeStrobeN)
        else $error("Write strobe width wrong");
    a_idle_deselect: assert property (@(posedge clock) disable iff (!resetn)
        state_q == IDLE && !reqReady |-> selectN)
        else $error("Select asserted while idle");
    a_select_pulse_width: assert property (@(posedge clock) disable iff (!resetn)
        $fell(selectN) && modeSel_q && state_q == STROBE |-> !selectN [*2] ##1 selectN)
        else $error("Select strobe width wrong");
    a_data_hold_strobe: assert property (@(posedge clock) disable iff (!resetn)
        $rose(writeStrobeN) && !modeSel_q |-> !selectN && $stable(write_data_in) && $stable(word_index))
        else $error("Select or data not held past strobe rise");
    a_release_after_access: assert property (@(posedge clock) disable iff (!resetn)
        state_q == HOLD |=> selectN && writeStrobeN)
        else $error("Select or strobe not released after write");

    c_normal_write: cover property (@(posedge clock) disable iff (!resetn)
        $fell(writeStrobeN) && !selectN);
    c_select_write: cover property (@(posedge clock) disable iff (!resetn)
        $fell(selectN) && !writeStrobeN);
    c_read_done: cover property (@(posedge clock) disable iff (!resetn) rspValid);
    c_select_end: cover property (@(posedge clock) disable iff (!resetn)
        state_q == HOLD && modeSel_q);
    c_normal_end: cover property (@(posedge clock) disable iff (!resetn)
        state_q == HOLD && !modeSel_q);
endmodule

//--- reg_file_model.sv
// Behavioural 16x4 register file at the controller's far side.
// Assumes level-sensitive select and strobe, both active low.
`timescale 1ns/100ps
module reg_file_model
    import regfile_host_pkg::*;
(
    input  wire logic                   selectN,
    input  wire logic                   writeStrobeN,
    input  wire logic [INDEX_WIDTH-1:0] word_index,
    input  wire logic [WORD_WIDTH-1:0]  write_data_in,
    output logic      [WORD_WIDTH-1:0]  read_data_out
);
    logic [WORD_WIDTH-1:0] store [WORD_COUNT];
    logic                  selLow;
    logic                  weLow;
    assign selLow = (selectN !== 1'b1);
    assign weLow  = (writeStrobeN !== 1'b1);
    always @* begin
        if (selLow && weLow) begin
            store[word_index] = write_data_in;
        end
    end
    assign read_data_out = (selLow && !weLow) ? store[word_index] : 4'h0;
endmodule

//--- tb_top.sv
// Self-checking bench for the register file controller.
// Assumes the behavioural model stands on the device pins.
`timescale 1ns/100ps
module tb_top
    import regfile_host_pkg::*;
;
    logic       clock, resetn, reqValid, reqWrite, strobeBySelect, reqReady, rspValid;
    logic [3:0] reqIndex, reqData, rspData, wordIndex, writeData, readOut;
    logic       selectN, writeStrobeN;
    int         mismatches, num_checks;
    regfile_host dut (.clock(clock), .resetn(resetn), .reqValid(reqValid), .reqWrite(reqWrite),
        .strobeBySelect(strobeBySelect), .reqIndex(reqIndex), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .word_index(wordIndex), .write_data_in(writeData),
        .selectN(selectN), .writeStrobeN(writeStrobeN), .read_data_out(readOut));
    reg_file_model model (.selectN(selectN), .writeStrobeN(writeStrobeN), .word_index(wordIndex),
        .write_data_in(writeData), .read_data_out(readOut));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic timeout();
        mismatches++;
        $display("unexpected hang at %0t", $time);
        stop_test();
    endtask
    task automatic doWrite(input logic [3:0] i, input logic [3:0] d, input logic sbs);
        int n;
        int lowCycles;
        lowCycles = 0;
        @(negedge clock);
        reqValid = 1'b1; reqWrite = 1'b1; strobeBySelect = sbs; reqIndex = i; reqData = d;
        @(negedge clock);
        reqValid = 1'b0;
        for (n = 0; n < 20 && reqReady !== 1'b1; n++) begin
            if (selectN === 1'b0 && writeStrobeN === 1'b0) begin
                lowCycles++;
                check(wordIndex, i);
                check(writeData, d);
                check(readOut, 4'h0);
            end
            if (sbs && selectN === 1'b0) check({3'h0, writeStrobeN}, 4'h0);
            if (!sbs && writeStrobeN === 1'b0) check({3'h0, selectN}, 4'h0);
            @(negedge clock);
        end
        if (n == 20) begin
            timeout();
        end else begin
            check(4'(lowCycles >= (sbs ? SELECT_PULSE_CYCLES : WRITE_PULSE_CYCLES)), 4'h1);
            check({2'h0, selectN, writeStrobeN}, 4'h3);
        end
    endtask
    task automatic doRead(input logic [3:0] i, input logic [3:0] exp);
        int n;
        @(negedge clock);
        reqValid = 1'b1; reqWrite = 1'b0; reqIndex = i;
        @(negedge clock);
        reqValid = 1'b0;
        for (n = 0; n < 20 && rspValid !== 1'b1; n++) @(negedge clock);
        if (n == 20) begin
            timeout();
        end else begin
            check(rspData, exp);
            check({3'h0, selectN}, 4'h1);
        end
    endtask
    initial begin
        mismatches = 0; num_checks = 0;
        resetn = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; strobeBySelect = 1'b0;
        reqIndex = 4'h0; reqData = 4'h0;
        repeat (10) @(negedge clock);
        check({3'h0, selectN}, 4'h1);
        check(readOut, 4'h0);
        resetn = 1'b1;
        @(negedge clock);
        for (int k = 0; k < 16; k++) doWrite(k[3:0], ~k[3:0], 1'b0);
        for (int k = 0; k < 16; k++) doRead(k[3:0], ~k[3:0]);
        for (int k = 0; k < 16; k += 5) doWrite(k[3:0], k[3:0] ^ 4'h5, 1'b1);
        for (int k = 0; k < 16; k++) doRead(k[3:0], (k % 5 == 0) ? (k[3:0] ^ 4'h5) : ~k[3:0]);
        doWrite(4'hf, 4'h0, 1'b0);
        doRead(4'hf, 4'h0);
        doWrite(4'h0, 4'hf, 1'b1);
        doRead(4'h0, 4'hf);
        check(readOut, 4'h0);
        stop_test();
    end
endmodule
